// *** hdl/cib_ctrl_bank.sv ***
`timescale 1ns/1ns
`default_nettype none
module cib_ctrl_bank
  import cib_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  input wire logic [15:0] hp_addr_i,
  input wire logic hp_wr_i,
  input wire logic hp_rd_i,
  input wire logic [15:0] hp_wdata_i,
  output logic [15:0] hp_rdata_o,
  input wire cib_irq_src_s irq_src_i,
  output cib_irq_src_s irq_gated_o,
  output logic gpio_pend_clr_o,
  output logic timer_one_pend_clr_o,
  output logic timer_zero_pend_clr_o,
  input wire logic [15:0] pc_i,
  input wire logic pc_valid_i,
  output logic breakpoint_vector_o,
  output cib_line_s [CIB_PORTS-1:0] usb_line_o
);

  logic [15:0] ien_r;
  logic [15:0] ien_nxt;
  logic [15:0] bkpt_r;
  logic [15:0] bkpt_nxt;
  logic [15:0] diag_r;
  logic [15:0] diag_nxt;
  logic bkpt_clear;
  logic bkpt_match;
  logic [7:0] div_r;
  logic toggle_tick_r;

  // Register write from either port; the processor wins a same-cycle tie.
  function automatic logic [15:0] reg_write(
    input logic [15:0] old_val,
    input logic [15:0] addr,
    input logic [15:0] cpu_data,
    input logic [15:0] hp_data,
    input logic [15:0] wmask
  );
    logic [15:0] val;
    val = old_val;
    if (hp_wr_i && hp_addr_i == addr) begin
      val = hp_data & wmask;
    end
    if (cpu_wr_i && cpu_addr_i == addr) begin
      val = cpu_data & wmask;
    end
    return val;
  endfunction : reg_write

  // The host port never sees the diagnostic register; it reads as zero.
  function automatic logic [15:0] reg_read(
    input logic [15:0] addr,
    input logic from_host
  );
    logic [15:0] val;
    val = CIB_ZERO16;
    unique case (addr)
      CIB_IEN_ADDR: val = ien_r | CIB_IEN_RSV_ONE;
      CIB_BKPT_ADDR: val = bkpt_r;
      CIB_DIAG_ADDR: val = from_host ? CIB_ZERO16 : diag_r;
      default: val = CIB_ZERO16;
    endcase
    return val;
  endfunction : reg_read

  function automatic cib_irq_src_s gate_irq(
    input cib_irq_src_s src,
    input logic [15:0] en
  );
    cib_irq_src_s g;
    g = src;
    g.otg = src.otg & en[CIB_EN_OTG];
    g.spi = src.spi & {3{en[CIB_EN_SPI]}};
    g.usb2 = src.usb2 & {6{en[CIB_EN_USB2]}};
    g.usb1 = src.usb1 & {6{en[CIB_EN_USB1]}};
    g.high_speed_serial = src.high_speed_serial &
                          {2{en[CIB_EN_HSS]}};
    g.inbound_mailbox_irq = src.inbound_mailbox_irq &
                            en[CIB_EN_MBXIN];
    g.outbound_mailbox_irq = src.outbound_mailbox_irq &
                             en[CIB_EN_MBXOUT];
    g.uart = src.uart & {2{en[CIB_EN_UART]}};
    g.gpio = src.gpio & en[CIB_EN_GPIO];
    g.timer_one_irq = src.timer_one_irq & en[CIB_EN_TMR1];
    g.timer_zero_irq = src.timer_zero_irq & en[CIB_EN_TMR0];
    return g;
  endfunction : gate_irq

  // Reserved bits are masked off so a careless write cannot set them.
  always_comb begin
    ien_nxt = reg_write(ien_r, CIB_IEN_ADDR, cpu_wdata_i, hp_wdata_i,
                        CIB_IEN_WMASK);
    bkpt_nxt = reg_write(bkpt_r, CIB_BKPT_ADDR, cpu_wdata_i, hp_wdata_i,
                         16'hffff);
    diag_nxt = reg_write(diag_r, CIB_DIAG_ADDR, cpu_wdata_i, hp_wdata_i,
                         CIB_DIAG_WMASK);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ien_r <= CIB_IEN_RESET;
    end else begin
      ien_r <= ien_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bkpt_r <= CIB_BKPT_RESET;
    end else begin
      bkpt_r <= bkpt_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_r <= CIB_DIAG_RESET;
    end else begin
      diag_r <= diag_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_rdata_o <= CIB_ZERO16;
    end else if (cpu_rd_i) begin
      cpu_rdata_o <= reg_read(cpu_addr_i, 1'b0);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hp_rdata_o <= CIB_ZERO16;
    end else if (hp_rd_i) begin
      hp_rdata_o <= reg_read(hp_addr_i, 1'b1);
    end
  end

  // Gating is registered, so a cleared enable silences its source one
  // cycle later; the pending-clear pulses leave one edge earlier, as ien_r loads.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_gated_o <= '0;
    end else begin
      irq_gated_o <= gate_irq(irq_src_i, ien_r);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_pend_clr_o <= 1'b0;
      timer_one_pend_clr_o <= 1'b0;
      timer_zero_pend_clr_o <= 1'b0;
    end else begin
      gpio_pend_clr_o <= ien_r[CIB_EN_GPIO] &
                         ~ien_nxt[CIB_EN_GPIO];
      timer_one_pend_clr_o <= ien_r[CIB_EN_TMR1] &
                              ~ien_nxt[CIB_EN_TMR1];
      timer_zero_pend_clr_o <= ien_r[CIB_EN_TMR0] &
                               ~ien_nxt[CIB_EN_TMR0];
    end
  end

  // A zero address doubles as the clear code, so it never arms a match.
  assign bkpt_match = pc_valid_i && bkpt_r != CIB_ZERO16 &&
                      pc_i == bkpt_r;
  assign bkpt_clear = bkpt_nxt == CIB_ZERO16 &&
                      ((cpu_wr_i && cpu_addr_i == CIB_BKPT_ADDR) ||
                       (hp_wr_i && hp_addr_i == CIB_BKPT_ADDR));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      breakpoint_vector_o <= 1'b0;
    end else if (bkpt_match) begin
      breakpoint_vector_o <= 1'b1;
    end else if (bkpt_clear) begin
      breakpoint_vector_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= CIB_DIV_ZERO;
      toggle_tick_r <= 1'b0;
    end else if (div_r == CIB_TOGGLE_DIV - CIB_DIV_ONE) begin
      div_r <= CIB_DIV_ZERO;
      toggle_tick_r <= 1'b1;
    end else begin
      div_r <= div_r + CIB_DIV_ONE;
      toggle_tick_r <= 1'b0;
    end
  end

  for (genvar p = 0; p < CIB_PORTS; p++) begin : g_port
    cib_line_force u_force (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .port_en_i(diag_r[CIB_DIAG_PORT_LSB + p]),
      .force_sel_i(diag_r[CIB_FORCE_LSB +: CIB_FORCE_W]),
      .pulldown_i(diag_r[CIB_DIAG_PD]),
      .ls_pullup_i(diag_r[CIB_DIAG_LSPU]),
      .fs_pullup_i(diag_r[CIB_DIAG_FSPU]),
      .toggle_tick_i(toggle_tick_r),
      .line_o(usb_line_o[p])
    );
  end

  sequence s_bkpt_hit;
    pc_valid_i && pc_i == bkpt_r && bkpt_r != CIB_ZERO16;
  endsequence

  sequence s_bkpt_zero_write;
    cpu_wr_i && cpu_addr_i == CIB_BKPT_ADDR && cpu_wdata_i == CIB_ZERO16;
  endsequence

  sequence s_bkpt_miss;
    !(pc_valid_i && pc_i == bkpt_r && bkpt_r != CIB_ZERO16);
  endsequence

  otg_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 irq_gated_o.otg == $past(irq_src_i.otg && ien_r[CIB_EN_OTG])
  ) else $error("OTG gating wrong");

  spi_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ien_r[CIB_EN_SPI] |=> irq_gated_o.spi == 3'h0
  ) else $error("SPI passed while disabled");

  usb_two_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    ien_r[CIB_EN_USB2] |=> irq_gated_o.usb2 == $past(irq_src_i.usb2)
  ) else $error("Engine two gating wrong");

  usb_one_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    ##1 irq_gated_o.usb1 == ($past(irq_src_i.usb1) &
                             {6{$past(ien_r[CIB_EN_USB1])}})
  ) else $error("Engine one gating wrong");

  serial_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    ##1 irq_gated_o.high_speed_serial ==
        ($past(irq_src_i.high_speed_serial) & {2{$past(ien_r[CIB_EN_HSS])}})
  ) else $error("Serial gating wrong");

  mailbox_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    ##1 irq_gated_o.inbound_mailbox_irq ==
        $past(irq_src_i.inbound_mailbox_irq && ien_r[CIB_EN_MBXIN]) &&
        irq_gated_o.outbound_mailbox_irq ==
        $past(irq_src_i.outbound_mailbox_irq && ien_r[CIB_EN_MBXOUT])
  ) else $error("Mailbox gating wrong");

  uart_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ien_r[CIB_EN_UART] |=> irq_gated_o.uart == 2'h0
  ) else $error("UART passed while disabled");

  gpio_clear_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    $fell(ien_r[CIB_EN_GPIO]) |-> gpio_pend_clr_o ##1
      !gpio_pend_clr_o && !irq_gated_o.gpio
  ) else $error("GPIO pending not cleared");

  timer_clear_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    timer_one_pend_clr_o || timer_zero_pend_clr_o |->
      ($fell(ien_r[CIB_EN_TMR1]) == timer_one_pend_clr_o) &&
      ($fell(ien_r[CIB_EN_TMR0]) == timer_zero_pend_clr_o)
  ) else $error("Timer pending clear mistimed");

  bkpt_raise_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_bkpt_hit |=> breakpoint_vector_o
  ) else $error("Breakpoint not raised");

  bkpt_clear_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    s_bkpt_zero_write ##0 s_bkpt_miss |=>
      !breakpoint_vector_o && bkpt_r == CIB_ZERO16
  ) else $error("Breakpoint not cleared");

  diag_host_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hp_rd_i && hp_addr_i == CIB_DIAG_ADDR |=> hp_rdata_o == CIB_ZERO16
  ) else $error("Diagnostic readable from host");

  port_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !diag_r[CIB_DIAG_PORT_LSB] |=> usb_line_o[0] == '0
  ) else $error("Disabled port driven");

  pulls_follow_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i)
    diag_r[CIB_DIAG_PORT_LSB + 3] ##1 diag_r[CIB_DIAG_PORT_LSB + 3] |->
      usb_line_o[3].pulldown_en == $past(diag_r[CIB_DIAG_PD]) &&
      usb_line_o[3].ls_pullup_en == $past(diag_r[CIB_DIAG_LSPU]) &&
      usb_line_o[3].fs_pullup_en == $past(diag_r[CIB_DIAG_FSPU])
  ) else $error("Pull controls wrong");

  reset_clear_a: assert property (@(posedge clk_sys_i)
    $rose(rst_n_i) |-> ien_r == CIB_IEN_RESET && irq_gated_o == '0
  ) else $error("Enables not cleared by reset");

endmodule : cib_ctrl_bank
`default_nettype wire

// *** hdl/cib_line_force.sv ***
`timescale 1ns/1ns
`default_nettype none
module cib_line_force
  import cib_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic port_en_i,
  input wire logic [CIB_FORCE_W-1:0] force_sel_i,
  input wire logic pulldown_i,
  input wire logic ls_pullup_i,
  input wire logic fs_pullup_i,
  input wire logic toggle_tick_i,
  output cib_line_s line_o
);

  logic phase_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 1'b0;
    end else if (toggle_tick_i) begin
      phase_r <= ~phase_r;
    end
  end

  // A disabled port drives nothing so the transceiver keeps normal control.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_o <= '0;
    end else if (!port_en_i) begin
      line_o <= '0;
    end else begin
      line_o.drive_en <= 1'b1;
      line_o.pulldown_en <= pulldown_i;
      line_o.ls_pullup_en <= ls_pullup_i;
      line_o.fs_pullup_en <= fs_pullup_i;
      if (force_sel_i[CIB_FORCE_SE0]) begin
        line_o.dp <= 1'b0;
        line_o.dm <= 1'b0;
      end else if (force_sel_i[CIB_FORCE_TGL]) begin
        line_o.dp <= phase_r;
        line_o.dm <= ~phase_r;
      end else begin
        line_o.dp <= force_sel_i[CIB_FORCE_J];
        line_o.dm <= ~force_sel_i[CIB_FORCE_J];
      end
    end
  end

  force_se0_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    port_en_i && force_sel_i[CIB_FORCE_SE0] |=> !line_o.dp && !line_o.dm
  ) else $error("SE0 not forced");

  force_jk_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    port_en_i && force_sel_i[CIB_FORCE_W-1:CIB_FORCE_TGL] == 2'b00
    |=> line_o.dp == $past(force_sel_i[CIB_FORCE_J]) &&
        line_o.dm != line_o.dp
  ) else $error("J or K state wrong");

endmodule : cib_line_force
`default_nettype wire

// *** hdl/cib_pkg.sv ***
package cib_pkg;

  localparam logic [15:0] CIB_IEN_ADDR = 16'hc00e;
  localparam logic [15:0] CIB_BKPT_ADDR = 16'hc014;
  localparam logic [15:0] CIB_DIAG_ADDR = 16'hc03c;

  localparam logic [15:0] CIB_IEN_WMASK = 16'h1bef;
  localparam logic [15:0] CIB_IEN_RSV_ONE = 16'h0010;
  localparam logic [15:0] CIB_DIAG_WMASK = 16'hf077;
  localparam logic [15:0] CIB_IEN_RESET = 16'h0000;
  localparam logic [15:0] CIB_BKPT_RESET = 16'h0000;
  localparam logic [15:0] CIB_DIAG_RESET = 16'h0000;
  localparam logic [15:0] CIB_ZERO16 = 16'h0000;

  localparam int CIB_EN_OTG = 12;
  localparam int CIB_EN_SPI = 11;
  localparam int CIB_EN_USB2 = 9;
  localparam int CIB_EN_USB1 = 8;
  localparam int CIB_EN_HSS = 7;
  localparam int CIB_EN_MBXIN = 6;
  localparam int CIB_EN_MBXOUT = 5;
  localparam int CIB_EN_UART = 3;
  localparam int CIB_EN_GPIO = 2;
  localparam int CIB_EN_TMR1 = 1;
  localparam int CIB_EN_TMR0 = 0;

  localparam int CIB_PORTS = 4;
  localparam int CIB_DIAG_PORT_LSB = 12;
  localparam int CIB_DIAG_PD = 6;
  localparam int CIB_DIAG_LSPU = 5;
  localparam int CIB_DIAG_FSPU = 4;
  localparam int CIB_FORCE_LSB = 0;
  localparam int CIB_FORCE_W = 3;
  localparam int CIB_FORCE_SE0 = 2;
  localparam int CIB_FORCE_TGL = 1;
  localparam int CIB_FORCE_J = 0;

  localparam int CIB_CLK_HZ = 25_000_000;
  localparam int CIB_TOGGLE_HZ = 1_000_000;
  localparam logic [7:0] CIB_TOGGLE_DIV = 8'(CIB_CLK_HZ / CIB_TOGGLE_HZ);
  localparam logic [7:0] CIB_DIV_ONE = 8'h01;
  localparam logic [7:0] CIB_DIV_ZERO = 8'h00;

  typedef struct packed {
    logic otg;
    logic [2:0] spi;
    logic [5:0] usb2;
    logic [5:0] usb1;
    logic [1:0] high_speed_serial;
    logic inbound_mailbox_irq;
    logic outbound_mailbox_irq;
    logic [1:0] uart;
    logic gpio;
    logic timer_one_irq;
    logic timer_zero_irq;
  } cib_irq_src_s;

  typedef struct packed {
    logic drive_en;
    logic dp;
    logic dm;
    logic pulldown_en;
    logic ls_pullup_en;
    logic fs_pullup_en;
  } cib_line_s;

endpackage : cib_pkg

// *** testbench/cib_ctrl_bank_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module cib_ctrl_bank_bench
  import cib_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_wr, cpu_rd, hp_wr, hp_rd, pc_valid;
  logic [15:0] cpu_addr, cpu_wdata, hp_addr, hp_wdata, pc;
  logic [15:0] cpu_rdata, hp_rdata, en_sh, en_nx;
  cib_irq_src_s src, gated, raise_q, drop_q, exp_q;
  logic gpio_clr, t1_clr, t0_clr, bkpt_irq;
  logic [2:0] clr_q;
  cib_line_s [CIB_PORTS-1:0] lines;
  logic [31:0] seed = 32'h0000003c;
  int err_total = 0;
  int checks_done = 0;

  always #20 clk_sys = ~clk_sys;

  cib_ctrl_bank cib_ctrl_bank_inst (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n),
    .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd),
    .cpu_wdata_i(cpu_wdata), .cpu_rdata_o(cpu_rdata),
    .hp_addr_i(hp_addr), .hp_wr_i(hp_wr), .hp_rd_i(hp_rd),
    .hp_wdata_i(hp_wdata), .hp_rdata_o(hp_rdata),
    .irq_src_i(src), .irq_gated_o(gated),
    .gpio_pend_clr_o(gpio_clr), .timer_one_pend_clr_o(t1_clr),
    .timer_zero_pend_clr_o(t0_clr), .pc_i(pc), .pc_valid_i(pc_valid),
    .breakpoint_vector_o(bkpt_irq), .usb_line_o(lines)
  );

  cib_src_model cib_src_model_inst (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .raise_i(raise_q),
    .drop_i(drop_q), .gpio_clr_i(gpio_clr), .t1_clr_i(t1_clr),
    .t0_clr_i(t0_clr), .src_o(src)
  );

  function automatic logic [31:0] nxt_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt_rand

  function automatic cib_irq_src_s exp_gate(input cib_irq_src_s s,
                                             input logic [15:0] e);
    return cib_irq_src_s'(s & {e[12], {3{e[11]}}, {6{e[9]}}, {6{e[8]}},
      {2{e[7]}}, e[6], e[5], {2{e[3]}}, e[2], e[1], e[0]});
  endfunction : exp_gate

  function automatic cib_line_s exp_line(input logic [15:0] d, input int i);
    cib_line_s l;
    l = '0;
    if (d[12+i]) begin
      l.drive_en = 1'b1;
      l.pulldown_en = d[6];
      l.ls_pullup_en = d[5];
      l.fs_pullup_en = d[4];
      l.dp = !d[2] && !d[1] && d[0];
      l.dm = !d[2] && !d[1] && !d[0];
    end
    return l;
  endfunction : exp_line

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task bus_wr(input logic hp, input logic [15:0] a, input logic [15:0] d);
    if (hp) begin
      hp_addr = a;
      hp_wdata = d;
      hp_wr = 1'b1;
    end else begin
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
    end
    @(negedge clk_sys);
    hp_wr = 1'b0;
    cpu_wr = 1'b0;
    // An idle cycle keeps a following call from re-raising a strobe at once.
    @(negedge clk_sys);
  endtask : bus_wr

  task bus_rd(input logic hp, input logic [15:0] a, output logic [15:0] d);
    hp_addr = a;
    cpu_addr = a;
    hp_rd = hp;
    cpu_rd = !hp;
    @(negedge clk_sys);
    hp_rd = 1'b0;
    cpu_rd = 1'b0;
    d = hp ? hp_rdata : cpu_rdata;
    @(negedge clk_sys);
  endtask : bus_rd

  task complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Shadow of the enable register; the processor wins a same-cycle write.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_sh <= '0;
      exp_q <= '0;
      clr_q <= '0;
    end else begin
      en_nx = en_sh;
      if (hp_wr && hp_addr == CIB_IEN_ADDR) en_nx = hp_wdata & 16'h1bef;
      if (cpu_wr && cpu_addr == CIB_IEN_ADDR) en_nx = cpu_wdata & 16'h1bef;
      exp_q <= exp_gate(src, en_sh);
      clr_q <= en_sh[2:0] & ~en_nx[2:0];
      en_sh <= en_nx;
    end
  end

  always @(negedge clk_sys) begin
    if (rst_n) begin
      check(gated[24:15], exp_q[24:15]);
      check(gated[14:5], exp_q[14:5]);
      check(gated[4:0], exp_q[4:0]);
      check({gpio_clr, t1_clr, t0_clr}, clr_q);
    end
  end

  initial begin
    repeat (10000) @(posedge clk_sys);
    err_total++;
    complete_run();
  end

  initial begin
    logic [15:0] rv, d, en_w;
    logic [31:0] r;
    {cpu_wr, cpu_rd, hp_wr, hp_rd, pc_valid} = '0;
    {cpu_addr, cpu_wdata, hp_addr, hp_wdata, pc} = '0;
    raise_q = '0;
    drop_q = '0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    bus_rd(0, CIB_IEN_ADDR, rv);
    check(rv, 16'h0010); // Reset value.
    bus_rd(1, CIB_IEN_ADDR, rv);
    check(rv, 16'h0010); // Reset value.
    bus_rd(0, CIB_BKPT_ADDR, rv);
    check(rv, 16'h0000); // Reset value.
    bus_rd(0, CIB_DIAG_ADDR, rv);
    check(rv, 16'h0000); // Reset value.
    bus_rd(0, 16'hc000, rv);
    check(rv, 16'h0000); // Unmapped read.
    bus_wr(1, 16'hc002, 16'hffff);
    bus_wr(0, CIB_IEN_ADDR, 16'hffff);
    bus_rd(1, CIB_IEN_ADDR, rv);
    check(rv, 16'h1bff); // Reserved bits masked.
    for (int n = 0; n < 300; n++) begin
      r = nxt_rand();
      raise_q = cib_irq_src_s'(r & nxt_rand());
      drop_q = cib_irq_src_s'(nxt_rand() & nxt_rand());
      pc = r[31:16];
      pc_valid = r[0];
      en_w = 16'(nxt_rand()) & 16'h1bef;
      if (r[3:1] == 3'h0) en_w = 16'h0000;
      if (r[3:1] == 3'h1) en_w = 16'h1bef;
      bus_wr(r[5], CIB_IEN_ADDR, en_w);
      if (r[6]) begin
        bus_rd(r[7], CIB_IEN_ADDR, rv);
        check(rv, en_w | 16'h0010); // Readback.
      end
      repeat (r[9:8]) @(negedge clk_sys);
    end
    raise_q = '0;
    drop_q = '0;
    pc_valid = 1'b0;
    check(bkpt_irq, 1'b0); // Address zero never matches.
    bus_wr(0, CIB_BKPT_ADDR, 16'h1234);
    bus_rd(1, CIB_BKPT_ADDR, rv);
    check(rv, 16'h1234); // Breakpoint readback.
    pc = 16'h1234;
    repeat (3) @(negedge clk_sys);
    check(bkpt_irq, 1'b0); // No match without valid.
    pc_valid = 1'b1;
    @(negedge clk_sys);
    pc_valid = 1'b0;
    pc = 16'h1235;
    repeat (2) @(negedge clk_sys);
    check(bkpt_irq, 1'b1); // Match raises vector.
    repeat (5) @(negedge clk_sys);
    check(bkpt_irq, 1'b1); // Vector holds.
    bus_wr(1, CIB_BKPT_ADDR, 16'h0000);
    repeat (2) @(negedge clk_sys);
    check(bkpt_irq, 1'b0); // Zero write clears.
    for (int f = 0; f < 8; f++) begin
      d = (16'(nxt_rand()) & 16'he070) | 16'h1000 | 16'(f);
      bus_wr(f == 5, CIB_DIAG_ADDR, d);
      bus_rd(0, CIB_DIAG_ADDR, rv);
      check(rv, d); // Processor read.
      bus_rd(1, CIB_DIAG_ADDR, rv);
      check(rv, 16'h0000); // Host port cannot read.
      @(negedge clk_sys);
      for (int i = 0; i < CIB_PORTS; i++) begin
        if (d[12+i] && d[2:1] == 2'b01) begin
          check(lines[i].dp ^ lines[i].dm, 1'b1); // Toggling.
          check(lines[i].drive_en, 1'b1);
          check(lines[i].pulldown_en, d[6]);
          check(lines[i].ls_pullup_en, d[5]);
          check(lines[i].fs_pullup_en, d[4]);
        end else begin
          check(lines[i], exp_line(d, i));
        end
      end
      if (d[2:1] == 2'b01) begin
        rv[0] = lines[0].dp;
        repeat (25) @(negedge clk_sys);
        check(lines[0].dp, !rv[0]); // One toggle per window.
      end
    end
    bus_wr(0, CIB_DIAG_ADDR, 16'h0077);
    repeat (3) @(negedge clk_sys);
    check(lines, '0); // Ports off act normally.
    complete_run();
  end
endmodule : cib_ctrl_bank_bench
`default_nettype wire

// *** testbench/cib_src_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cib_src_model
  import cib_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire cib_irq_src_s raise_i,
  input wire cib_irq_src_s drop_i,
  input wire logic gpio_clr_i,
  input wire logic t1_clr_i,
  input wire logic t0_clr_i,
  output cib_irq_src_s src_o
);
  // A request stays pending until serviced; a pending clear beats a raise.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_o <= '0;
    end else begin
      src_o <= cib_irq_src_s'((src_o & ~drop_i) | raise_i);
      if (gpio_clr_i) src_o.gpio <= 1'b0;
      if (t1_clr_i) src_o.timer_one_irq <= 1'b0;
      if (t0_clr_i) src_o.timer_zero_irq <= 1'b0;
    end
  end
endmodule : cib_src_model
`default_nettype wire
